// [hdl/encoder_cyclic_control_status.sv]
// Cyclic control and status word handling for a networked position encoder
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RQ1: Only bits 15..11 used of sensor words
// RQ2: Home request rising edge starts preset/offset
// RQ3: Mode zero: offset makes position equal preset
// RQ4: Mode one: preset added to offset
// RQ5: Controller loads preset before requesting
// RQ6: Controller holds request until done status
// RQ7: Done status rises after preset applied
// RQ8: Secondary channel: absolute or zero, no error
// RQ9: Absolute-sent status mirrors secondary channel content
// RQ10: Park bit parks device, clears errors
// RQ11: Parked status while commanded or initializing
// RQ12: Error sets ack-needed; ack clears it
// RQ13: Error status persists; diagnostic on secondary
// RQ14: Encoder control uses life count, bit 10
// RQ15: Control-by-PLC confirmation unless compatibility mode
// RQ16: Control-request status when control possible
// RQ17: Fault status bit while fault active
// RQ18: Warning bit always zero
// RQ19: Encoder life field stays zero
// RQ20: Right-aligned; shift factors zero-fill low bits
// RQ21: Primary 32 bits; wide upper half zero
// RQ22: Velocity right-aligned 16 and 32 bits
// RQ23: Preset value below total measurement range
module eccs_encoder_cyclic_control_status (
  input  wire logic                 mclk,
  input  wire logic                 resetn,
  input  wire eccs_pkg::eccs_ctrl_s ctrlIn,
  input  wire logic                 ctrlValid,
  input  wire logic [31:0]          rawPosition,
  input  wire logic [31:0]          rawVelocity,
  input  wire logic                 sensorError,
  input  wire logic [31:0]          diagCode,
  output var  eccs_pkg::eccs_stat_s statOut,
  output var  logic                 lifeFault,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output var  logic                 s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output var  logic                 s_axi_wready,
  output var  logic [1:0]           s_axi_bresp,
  output var  logic                 s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output var  logic                 s_axi_arready,
  output var  logic [31:0]          s_axi_rdata,
  output var  logic [1:0]           s_axi_rresp,
  output var  logic                 s_axi_rvalid,
  input  wire logic                 s_axi_rready
);
  import eccs_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [15:0] scw;
  logic [15:0] ecw;
  logic        homeReqPrev;
  eccs_home_e  homeState;
  logic [31:0] presetValue;
  logic [31:0] posOffset;
  logic [31:0] cfgWord;
  logic        ackNeeded;
  logic        errPrev;
  logic [3:0]  lifePrev;
  logic        accepted;
  logic        awHeld;
  logic        wHeld;
  logic [7:0]  awAddr;
  logic [31:0] wData;
  logic [3:0]  wStrb;

  // ---------------------------------------------------------------
  // Derived terms
  // ---------------------------------------------------------------
  logic        parked;
  logic        errActive;
  logic        accept;
  logic [31:0] position;
  logic [4:0]  shift1;
  logic [4:0]  shift2;
  logic [31:0] primaryVal;
  logic [31:0] absVal;
  logic        doWrite;

  // Park on command or until sensor data is ready
  assign parked    = scw[SCW_PARK] || !cfgWord[CFG_READY]; // [RQ10] [RQ11]
  assign errActive = sensorError && !parked;               // [RQ10]
  // Compatibility mode always accepts controller data
  assign accept    = cfgWord[CFG_COMPAT]
                     || ctrlIn.encoderControlWord[ECW_CTRL_PLC]; // [RQ15]
  assign position  = rawPosition + posOffset;
  assign shift1    = cfgWord[CFG_SHIFT1_LO +: 5];
  assign shift2    = cfgWord[CFG_SHIFT2_LO +: 5];
  // Low bits zero-filled when a shift factor is set
  assign primaryVal = (position >> shift1) << shift1;      // [RQ20]
  assign absVal     = (position >> shift2) << shift2;      // [RQ20]
  assign doWrite    = awHeld && wHeld && !s_axi_bvalid;

  // ---------------------------------------------------------------
  // Control word capture
  // ---------------------------------------------------------------
  // Unused bits are masked so they can never steer logic
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      scw      <= 16'h0000;
      ecw      <= 16'h0000;
      accepted <= 1'b0;
    end
    else if (ctrlValid)
    begin
      ecw      <= ctrlIn.encoderControlWord & ECW_MASK;   // [RQ14]
      accepted <= accept;
      if (accept)                                          // [RQ15]
      begin
        scw <= ctrlIn.sensorControlWord & SCW_MASK;        // [RQ1]
      end
    end
  end

  // Sign-of-life supervision: count must move each valid cycle that follows an accepted frame
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      lifePrev  <= 4'h0;
      lifeFault <= 1'b0;
    end
    else if (ctrlValid)
    begin
      lifePrev  <= ctrlIn.encoderControlWord[ECW_LIFE_LO +: 4]; // [RQ14]
      lifeFault <= accepted
                   && (ctrlIn.encoderControlWord[ECW_LIFE_LO +: 4]
                       == lifePrev);
    end
  end

  // ---------------------------------------------------------------
  // Preset / offset handshake
  // ---------------------------------------------------------------
  // One cycle to apply, then done holds until request drops
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      homeState   <= HOME_IDLE;
      homeReqPrev <= 1'b0;
      posOffset   <= RST_ZERO;
    end
    else
    begin
      homeReqPrev <= scw[SCW_HOME_REQ];
      case (homeState)
        HOME_IDLE:
        begin
          if (scw[SCW_HOME_REQ] && !homeReqPrev && !parked) // [RQ2]
          begin
            homeState <= HOME_APPLY;
          end
        end
        HOME_APPLY:
        begin
          if (scw[SCW_HOME_MODE])
          begin
            posOffset <= posOffset + presetValue;          // [RQ4]
          end
          else
          begin
            posOffset <= presetValue - rawPosition;        // [RQ3]
          end
          homeState <= HOME_DONE;
        end
        HOME_DONE:
        begin
          if (!scw[SCW_HOME_REQ])                          // [RQ6]
            homeState <= HOME_IDLE;
        end
        default:
        begin
          homeState <= HOME_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Error acknowledgement
  // ---------------------------------------------------------------
  // New error wins over an acknowledge in the same cycle
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      ackNeeded <= 1'b0;
      errPrev   <= 1'b0;
    end
    else
    begin
      errPrev <= errActive;
      if (parked)
        ackNeeded <= 1'b0;                                 // [RQ10]
      else if (errActive && !errPrev)
        ackNeeded <= 1'b1;                                 // [RQ12]
      else if (scw[SCW_ACK])
        ackNeeded <= 1'b0;                                 // [RQ12]
    end
  end

  // ---------------------------------------------------------------
  // Cyclic status and data words
  // ---------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      statOut <= '0;
    end
    else
    begin
      statOut.sensorStatusWord <= 16'h0000;                // [RQ1]
      // Masked by park so the flag never lags the parked status
      statOut.sensorStatusWord[SSW_ACK_REQD]  <=
        ackNeeded && !parked;                              // [RQ10] [RQ12]
      statOut.sensorStatusWord[SSW_HOME_DONE] <=
        (homeState == HOME_DONE);                          // [RQ7]
      statOut.sensorStatusWord[SSW_ABS_SENT]  <=
        scw[SCW_ABS_REQ] && !errActive && !parked;         // [RQ9]
      statOut.sensorStatusWord[SSW_PARKED]    <= parked;   // [RQ11]
      statOut.sensorStatusWord[SSW_ERROR]     <= errActive; // [RQ13]
      // Life field and warning bit stay zero
      statOut.encoderStatusWord <= 16'h0000;               // [RQ18] [RQ19]
      statOut.encoderStatusWord[ESW_FAULT]    <= errActive
                                                 || lifeFault; // [RQ17]
      statOut.encoderStatusWord[ESW_CTRL_REQ] <=
        !cfgWord[CFG_COMPAT] && !parked && !errActive;     // [RQ16]
      if (errActive)
        statOut.secondaryPositionOrError <= diagCode;      // [RQ13]
      else if (scw[SCW_ABS_REQ] && !parked)
        statOut.secondaryPositionOrError <= absVal;        // [RQ8]
      else
        statOut.secondaryPositionOrError <= RST_ZERO;      // [RQ8]
      // Primary is invalid while parked; zero is sent then
      statOut.primaryPosition <= parked ? RST_ZERO : primaryVal; // [RQ10]
      statOut.widePosition    <= {32'h0000_0000, position}; // [RQ21]
      statOut.shortVelocity   <= rawVelocity[15:0];        // [RQ22]
      statOut.longVelocity    <= rawVelocity;              // [RQ22]
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite write path
  // ---------------------------------------------------------------
  // Address and data latched independently, either order
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      awAddr        <= 8'h00;
      wData         <= RST_ZERO;
      wStrb         <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !awHeld && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !wHeld && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awready && s_axi_awvalid)
      begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wready && s_axi_wvalid)
      begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddr == ADDR_PRESET || awAddr == ADDR_CONFIG)
                        ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Writable registers with byte enables
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      presetValue <= RST_ZERO;
      cfgWord     <= RST_CONFIG;
    end
    else if (doWrite)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (wStrb[i] && awAddr == ADDR_PRESET)
        begin
          presetValue[8*i +: 8] <= wData[8*i +: 8];        // [RQ5] [RQ23]
        end
        else if (wStrb[i] && awAddr == ADDR_CONFIG)
        begin
          cfgWord[8*i +: 8] <= wData[8*i +: 8];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read path
  // ---------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= RST_ZERO;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arready && s_axi_arvalid)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        if (s_axi_araddr == ADDR_CTRL_IN)
        begin
          s_axi_rdata <= {scw, ecw};
        end
        else if (s_axi_araddr == ADDR_STATUS)
        begin
          s_axi_rdata <= {statOut.sensorStatusWord,
                          statOut.encoderStatusWord};
        end
        else if (s_axi_araddr == ADDR_PRESET)
        begin
          s_axi_rdata <= presetValue;
        end
        else if (s_axi_araddr == ADDR_CONFIG)
        begin
          s_axi_rdata <= cfgWord;
        end
        else if (s_axi_araddr == ADDR_PRIMARY)
        begin
          s_axi_rdata <= statOut.primaryPosition;
        end
        else if (s_axi_araddr == ADDR_SECONDARY)
        begin
          s_axi_rdata <= statOut.secondaryPositionOrError;
        end
        else if (s_axi_araddr == ADDR_OFFSET)
        begin
          s_axi_rdata <= posOffset;
        end
        else if (s_axi_araddr == ADDR_DIAG)
        begin
          s_axi_rdata <= diagCode;
        end
        else
        begin
          s_axi_rdata <= RST_ZERO;
          s_axi_rresp <= RESP_SLVERR;
        end
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : eccs_encoder_cyclic_control_status
`default_nettype wire

// [hdl/eccs_pkg.sv]
// Package of constants and carrier types for the cyclic control/status block
package eccs_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses, AXI4-Lite)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL_IN   = 8'h00; // Both control words
  localparam logic [7:0] ADDR_STATUS    = 8'h04; // Both status words
  localparam logic [7:0] ADDR_PRESET    = 8'h08; // Stored preset value
  localparam logic [7:0] ADDR_CONFIG    = 8'h0C; // Mode/shift config
  localparam logic [7:0] ADDR_PRIMARY   = 8'h10;
  localparam logic [7:0] ADDR_SECONDARY = 8'h14;
  localparam logic [7:0] ADDR_OFFSET    = 8'h18;
  localparam logic [7:0] ADDR_DIAG      = 8'h1C; // Diagnostic code

  // ---------------------------------------------------------------
  // Control and status bit positions
  // ---------------------------------------------------------------
  localparam int SCW_HOME_MODE  = 11;
  localparam int SCW_HOME_REQ   = 12;
  localparam int SCW_ABS_REQ    = 13;
  localparam int SCW_PARK       = 14;
  localparam int SCW_ACK        = 15;
  localparam int SSW_ACK_REQD   = 11;
  localparam int SSW_HOME_DONE  = 12;
  localparam int SSW_ABS_SENT   = 13;
  localparam int SSW_PARKED     = 14;
  localparam int SSW_ERROR      = 15;
  localparam int ECW_CTRL_PLC   = 10;
  localparam int ECW_LIFE_LO    = 12;
  localparam int ESW_FAULT      = 3;
  localparam int ESW_WARN       = 7;
  localparam int ESW_CTRL_REQ   = 9;
  localparam int CFG_COMPAT     = 0;
  localparam int CFG_READY      = 1;
  localparam int CFG_SHIFT1_LO  = 8;
  localparam int CFG_SHIFT2_LO  = 16;

  // Reset values, control word masks and response codes
  localparam logic [31:0] RST_CONFIG = 32'h0000_0000;
  localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
  localparam logic [15:0] SCW_MASK   = 16'hF800;
  localparam logic [15:0] ECW_MASK   = 16'hF400;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  // Cyclic data carriers
  typedef struct packed {
    logic [15:0] sensorControlWord;
    logic [15:0] encoderControlWord;
  } eccs_ctrl_s;

  typedef struct packed {
    logic [15:0] encoderStatusWord;
    logic [15:0] sensorStatusWord;
    logic [31:0] primaryPosition;
    logic [31:0] secondaryPositionOrError;
    logic [63:0] widePosition;
    logic [15:0] shortVelocity;
    logic [31:0] longVelocity;
  } eccs_stat_s;

  typedef enum logic [2:0] {
    HOME_IDLE  = 3'b001,
    HOME_APPLY = 3'b010,
    HOME_DONE  = 3'b100
  } eccs_home_e;

endpackage : eccs_pkg

// [testbench/eccs_ctrl_model.sv]
// Cyclic controller model driving the two control words
`timescale 1ns/1ps
`default_nettype none
module eccs_ctrl_model
  import eccs_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic [4:0] cmdBits,
  input  wire logic       plcCtrl,
  input  wire logic       stallLife,
  input  wire logic       homeGo,
  input  wire logic       homeDone,
  output var  eccs_ctrl_s ctrlIn,
  output var  logic       ctrlValid
);
  logic [3:0]  life;
  logic        homeReq;
  logic [15:0] junk;

  // One frame per clock; unused bits carry junk so they get exercised
  always_ff @(posedge mclk)
    if (!resetn)
    begin
      life      <= 4'h0;
      junk      <= 16'h0000;
      ctrlValid <= 1'b0;
    end
    else
    begin
      ctrlValid <= 1'b1;
      junk      <= junk + 16'h2B5D;
      if (!stallLife)
        life <= life + 4'h1; // Sign-of-life count
    end

  // Request held until the done status is seen
  always_ff @(posedge mclk)
    if (!resetn)
      homeReq <= 1'b0;
    else if (homeGo)
      homeReq <= 1'b1;
    else if (homeDone)
      homeReq <= 1'b0;

  // Control words; the PLC bit confirms control
  always_comb
  begin
    ctrlIn.sensorControlWord  = {cmdBits[4:2], homeReq, cmdBits[0],
                                 junk[10:0]};
    ctrlIn.encoderControlWord = {life, junk[11], plcCtrl, junk[9:0]};
  end
endmodule : eccs_ctrl_model
`default_nettype wire

// [testbench/eccs_asserts.sv]
// Concurrent checks on the cyclic control and status outputs
`timescale 1ns/1ps
`default_nettype none
module eccs_asserts
  import eccs_pkg::*;
(
  input wire logic                 mclk,
  input wire logic                 resetn,
  input wire eccs_pkg::eccs_ctrl_s ctrlIn,
  input wire logic                 ctrlValid,
  input wire logic [31:0]          rawVelocity,
  input wire logic                 sensorError,
  input wire logic [31:0]          diagCode,
  input wire eccs_pkg::eccs_stat_s statOut
);
  logic        upQ;
  logic [3:0]  homeAge;
  logic [15:0] ssw;
  logic [15:0] esw;
  assign ssw = statOut.sensorStatusWord;
  assign esw = statOut.encoderStatusWord;
  // Outputs lag inputs one edge, so skip the first edge after release
  always_ff @(posedge mclk)
    upQ <= resetn;
  // Cycles since a home request was last offered
  always_ff @(posedge mclk)
    if (!resetn)
      homeAge <= 4'hF;
    else if (ctrlValid && ctrlIn.sensorControlWord[SCW_HOME_REQ])
      homeAge <= 4'h0;
    else if (homeAge != 4'hF)
      homeAge <= homeAge + 4'h1;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn || !upQ);

  a_warn_life: assert property (
    esw[7] == 1'b0 && esw[15:12] == 4'h0) else $error("warn/life set");
  a_sensor_unused: assert property (
    ssw[10:0] == 11'h000) else $error("low status bits set");
  a_wide_upper: assert property (
    statOut.widePosition[63:32] == 32'h0000_0000) else $error("wide hi");
  a_error_diag: assert property (
    ssw[15] |-> statOut.secondaryPositionOrError == $past(diagCode))
    else $error("diag code missing");
  a_abs_valid: assert property (
    ssw[13] |-> !ssw[15] && !ssw[14]) else $error("abs flag wrong");
  a_secondary_zero: assert property (
    !ssw[13] && !ssw[15] && !$past(sensorError)
    |-> statOut.secondaryPositionOrError == 32'h0000_0000)
    else $error("secondary not zero");
  a_park_clears: assert property (
    ssw[14] |-> !ssw[15] && !ssw[11]
    && statOut.primaryPosition == 32'h0000_0000) else $error("park");
  a_fault_error: assert property (
    ssw[15] |-> esw[3]) else $error("fault bit low on error");
  a_ctrl_req: assert property (
    esw[9] |-> !ssw[14] && !ssw[15]) else $error("control request");
  a_velocity_align: assert property (
    {16'h0000, statOut.shortVelocity} == ($past(rawVelocity) & 32'h0000_FFFF)
    && statOut.longVelocity == $past(rawVelocity)) else $error("vel");
  a_home_cause: assert property (
    $rose(ssw[12]) |-> homeAge <= 4'h6) else $error("home done uncaused");
  a_ack_raise: assert property (
    $rose(ssw[11]) |-> $past(ssw[15])) else $error("ack flag without error");

  c_home: cover property ($rose(ssw[12]));
  c_error: cover property (ssw[15] && ssw[11]);
  c_abs: cover property (ssw[13]);
  c_life: cover property (esw[3] && !ssw[15]);
endmodule : eccs_asserts

bind eccs_encoder_cyclic_control_status eccs_asserts eccs_asserts_i (
  .mclk(mclk), .resetn(resetn), .ctrlIn(ctrlIn), .ctrlValid(ctrlValid),
  .rawVelocity(rawVelocity), .sensorError(sensorError),
  .diagCode(diagCode), .statOut(statOut));
`default_nettype wire

// [testbench/eccs_encoder_cyclic_control_status_tb.sv]
// Self-checking bench for the cyclic control and status block
`timescale 1ns/1ps
`default_nettype none
module eccs_encoder_cyclic_control_status_tb;
  import eccs_pkg::*;
  logic        mclk, resetn, ctrlValid, sensorError, lifeFault;
  logic        plcCtrl, stallLife, homeGo;
  logic [4:0]  cmdBits;
  eccs_ctrl_s  ctrlIn;
  eccs_stat_s  statOut;
  logic [31:0] rawPosition, rawVelocity, diagCode, offsetExp, pv, rd;
  logic [7:0]  awaddr, araddr;
  logic [3:0]  wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, rs;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [15:0] ssw, esw;
  int          miscompares, compares, seed;
  assign ssw = statOut.sensorStatusWord;
  assign esw = statOut.encoderStatusWord;

  eccs_encoder_cyclic_control_status eccs_encoder_cyclic_control_status_i (
    .mclk(mclk), .resetn(resetn), .ctrlIn(ctrlIn), .ctrlValid(ctrlValid),
    .rawPosition(rawPosition), .rawVelocity(rawVelocity),
    .sensorError(sensorError), .diagCode(diagCode), .statOut(statOut),
    .lifeFault(lifeFault), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  eccs_ctrl_model eccs_ctrl_model_i (
    .mclk(mclk), .resetn(resetn), .cmdBits(cmdBits), .plcCtrl(plcCtrl),
    .stallLife(stallLife), .homeGo(homeGo), .homeDone(ssw[12]),
    .ctrlIn(ctrlIn), .ctrlValid(ctrlValid));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic checkWord(input string what, input logic [63:0] exp,
                           input logic [63:0] got);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : checkWord
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  // Bus write; each channel released at its own handshake edge
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic got;
    @(posedge mclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    bready <= 1'b1; n = 0; got = 1'b0;
    while (n < 64 && !got)
    begin
      @(posedge mclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin rs = bresp; bready <= 1'b0; got = 1'b1; end
    end
    if (!got) miscompares++;
  endtask : axiWrite
  task automatic axiRead(input logic [7:0] a);
    int n;
    logic got;
    @(posedge mclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1; n = 0; got = 1'b0;
    while (n < 64 && !got)
    begin
      @(posedge mclk);
      n++;
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin rd = rdata; rs = rresp; rready <= 1'b0; got = 1; end
    end
    if (!got) miscompares++;
  endtask : axiRead
  // Cyclic words need two edges to show; margin for the frame lag
  task automatic settle;
    repeat (4) @(posedge mclk);
  endtask : settle
  task automatic homeOp(input logic mode);
    int n;
    @(posedge mclk);
    cmdBits[0] <= mode; homeGo <= 1'b1;
    @(posedge mclk);
    homeGo <= 1'b0; n = 0;
    while (n < 20 && ssw[12] !== 1'b1) begin @(posedge mclk); n++; end
    checkWord("home done", 1, ssw[12]);
    n = 0;
    while (n < 20 && ssw[12] !== 1'b0) begin @(posedge mclk); n++; end
    checkWord("home clear", 0, ssw[12]);
  endtask : homeOp
  function automatic logic [31:0] posExp(input logic [31:0] raw);
    return raw + offsetExp;
  endfunction : posExp

  // ----------------------------------------------------------------
  // Clock, watchdog, main sequence
  // ----------------------------------------------------------------
  initial begin mclk = 1'b0; forever #50 mclk = ~mclk; end
  initial begin #500000; miscompares++; complete_run(); end
  initial
  begin
    seed = 73; resetn = 0; cmdBits = 0; plcCtrl = 0; stallLife = 0;
    homeGo = 0; sensorError = 0; diagCode = 0; rawPosition = 0;
    rawVelocity = 0; awaddr = 0; araddr = 0; wdata = 0; awvalid = 0;
    wvalid = 0; bready = 0; arvalid = 0; rready = 0; offsetExp = 0;
    miscompares = 0; compares = 0; wstrb = 4'hF;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    settle();
    checkWord("init park", 1, ssw[14]);
    axiRead(8'h20);
    checkWord("unmapped", {RESP_SLVERR, 32'h0000_0000}, {rs, rd});
    axiWrite(ADDR_PRIMARY, 32'h0000_1234);
    checkWord("ro write", RESP_SLVERR, rs);
    plcCtrl <= 1'b1;
    axiWrite(ADDR_CONFIG, 32'h0000_0002);
    settle();
    checkWord("ready", 2'b01, {ssw[14], esw[9]});
    cmdBits <= 5'b00100;
    repeat (6)
    begin
      rawPosition <= $random(seed);
      rawVelocity <= $random(seed);
      settle();
      checkWord("abs sec", {1'b1, posExp(rawPosition)},
                {ssw[13], statOut.secondaryPositionOrError});
      checkWord("wide", posExp(rawPosition), statOut.widePosition);
      checkWord("long vel", rawVelocity, statOut.longVelocity);
    end
    cmdBits <= 5'b00000;
    settle();
    checkWord("sec off", 0, {ssw[13], statOut.secondaryPositionOrError});
    pv = $random(seed) & 32'h00FF_FFFF;
    axiWrite(ADDR_PRESET, pv);
    homeOp(1'b0);
    offsetExp = pv - rawPosition;
    checkWord("preset", pv, statOut.primaryPosition);
    pv = $random(seed) & 32'h0000_FFFF;
    axiWrite(ADDR_PRESET, pv);
    homeOp(1'b1);
    offsetExp = offsetExp + pv;
    checkWord("offset", posExp(rawPosition), statOut.primaryPosition);
    axiRead(ADDR_OFFSET);
    checkWord("offset reg", offsetExp, rd);
    wstrb <= 4'h3;
    axiWrite(ADDR_PRESET, 32'hFFFF_FFFF);
    wstrb <= 4'hF;
    axiRead(ADDR_PRESET);
    checkWord("strobe", {pv[31:16], 16'hFFFF}, rd);
    plcCtrl <= 1'b0; cmdBits <= 5'b00100;
    settle();
    checkWord("no plc", 0, ssw[13]);
    plcCtrl <= 1'b1;
    settle();
    checkWord("plc", 1, ssw[13]);
    axiWrite(ADDR_CONFIG, 32'h0000_0003);
    plcCtrl <= 1'b0; cmdBits <= 5'b00000;
    settle();
    checkWord("compat", 2'b00, {ssw[13], esw[9]});
    plcCtrl <= 1'b1; diagCode <= $random(seed); sensorError <= 1'b1;
    settle();
    checkWord("err", 3'b111, {ssw[15], ssw[11], esw[3]});
    checkWord("diag", diagCode, statOut.secondaryPositionOrError);
    cmdBits <= 5'b10000;
    settle();
    checkWord("ack", 2'b10, {ssw[15], ssw[11]});
    cmdBits <= 5'b01000;
    settle();
    checkWord("park", 3'b100, {ssw[14], ssw[15], ssw[11]});
    cmdBits <= 5'b00100; sensorError <= 1'b0;
    axiWrite(ADDR_CONFIG, 32'h0005_0402);
    rawPosition <= 32'hFFFF_FFFF - offsetExp;
    settle();
    checkWord("shift", {32'hFFFF_FFF0, 32'hFFFF_FFE0},
              {statOut.primaryPosition, statOut.secondaryPositionOrError});
    checkWord("fault off", 0, {ssw[15], esw[3]});
    stallLife <= 1'b1;
    settle();
    checkWord("life stall", 2'b11, {lifeFault, esw[3]});
    stallLife <= 1'b0;
    settle();
    checkWord("life ok", 2'b00, {lifeFault, esw[3]});
    complete_run();
  end
endmodule : eccs_encoder_cyclic_control_status_tb
`default_nettype wire
